/* File: core/vectored_transfer_engine.sv */
// The address map and the APB slave port are this design's own decisions.
`include "vte_map.svh"
`timescale 1ns/1ps
`default_nettype none

module vectored_transfer_engine (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // activation sources
    input wire logic [7:0] act_req,
    output logic [7:0] act_ack,
    output logic [7:0] cpu_irq,
    // internal bus master
    output vte_pkg::mem_req_type mem_req,
    input wire vte_pkg::mem_rsp_type mem_rsp
);
    import vte_pkg::*;

    state_type st_r;
    logic [31:0] ctrl_r, vbr_r, prdata_r, desc_addr_r, sar_r, dar_r, data_r;
    logic [7:0] en_r, done_r, mra_r, mrb_r, ack_r, irq_r, enclr_r;
    logic [15:0] cra_r, crb_r;
    logic [2:0] src_r, last_src_r;
    logic [1:0] idx_r;
    logic cache_ok_r, fin_r, gap_r;
    mem_req_type mreq_r;

    logic apb_wr, apb_mapped, cfg_wr, got, issue, short_mode, acc_we;
    logic [1:0] brel, last_idx, md, sz, acc_size;
    logic [7:0] pend;
    logic [2:0] pick;
    logic [31:0] sar_step, dar_step, acc_addr, acc_wdata, wb_word;

    // apb decode
    assign apb_wr = psel & penable & pwrite;
    assign apb_mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_VBR) ||
        (paddr == `OFS_ENABLE) || (paddr == `OFS_STATUS) ||
        (paddr == `OFS_DONE);
    assign cfg_wr = apb_wr & ((paddr == `OFS_CTRL) || (paddr == `OFS_VBR));
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~apb_mapped;
    assign prdata = prdata_r;

    // control, vector base and enable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RST;
            vbr_r <= `VBR_RST;
            en_r <= `ENABLE_RST;
        end else begin
            if (apb_wr && paddr == `OFS_CTRL) begin
                ctrl_r <= {26'h000_0000, pwdata[5:0]};
            end
            if (apb_wr && paddr == `OFS_VBR) begin
                vbr_r <= {pwdata[31:2], 2'b00};
            end
            if (apb_wr && paddr == `OFS_ENABLE) begin
                en_r <= pwdata[7:0] & ~enclr_r;
            end else begin
                en_r <= en_r & ~enclr_r;
            end
        end
    end

    // completion flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 8'h00;
        end else if (apb_wr && paddr == `OFS_DONE) begin
            done_r <= (done_r & ~pwdata[7:0]) | enclr_r;
        end else begin
            done_r <= done_r | enclr_r;
        end
    end

    // read data latched in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                `OFS_CTRL: prdata_r <= ctrl_r;
                `OFS_VBR: prdata_r <= vbr_r;
                `OFS_ENABLE: prdata_r <= {24'h00_0000, en_r};
                `OFS_STATUS: prdata_r <= {25'h000_0000, src_r,
                    3'b000, st_r != ST_IDLE};
                `OFS_DONE: prdata_r <= {24'h00_0000, done_r};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // source selection
    function automatic logic [2:0] pick_src(input logic [7:0] p,
            input logic rr, input logic [2:0] last);
        logic [2:0] k;
        logic [2:0] res;
        logic found;
        res = 3'd0;
        found = 1'b0;
        for (int i = 0; i < 8; i++) begin
            k = rr ? 3'(last + 3'(i) + 3'd1) : 3'(i);
            if (!found && p[k]) begin
                res = k;
                found = 1'b1;
            end
        end
        return res;
    endfunction : pick_src

    // address step per mode and unit size
    function automatic logic [31:0] step(input logic [1:0] am,
            input logic [1:0] s);
        logic [31:0] u;
        u = 32'h0000_0001 << s;
        return (am == `AM_INC) ? u : (am == `AM_DEC) ? 32'h0000_0000 - u :
            32'h0000_0000;
    endfunction : step

    // rewind a repeat or block area to its start
    function automatic logic [31:0] rewind(input logic [31:0] a,
            input logic [1:0] am, input logic [1:0] s,
            input logic [7:0] rel);
        logic [31:0] d;
        d = {23'h00_0000, rel == 8'h00, rel} << s;
        return (am == `AM_INC) ? a - d : (am == `AM_DEC) ? a + d : a;
    endfunction : rewind

    assign short_mode = ctrl_r[`CTRL_SHORT];
    assign brel = ctrl_r[`CTRL_BREL +: 2];
    assign last_idx = short_mode ? `DESC_LAST_SHORT : `DESC_LAST_FULL;
    assign pend = act_req & en_r;
    assign pick = pick_src(pend, ctrl_r[`CTRL_PRIO], last_src_r);
    assign md = mra_r[`MD_LSB +: 2];
    assign sz = mra_r[`SZ_LSB +: 2];
    assign sar_step = step(mra_r[`SM_LSB +: 2], sz);
    assign dar_step = step(mrb_r[`DM_LSB +: 2], sz);
    assign got = mreq_r.req & mem_rsp.ack;
    assign issue = !mreq_r.req && !gap_r && (st_r == ST_VEC ||
        st_r == ST_DESC || st_r == ST_RD || st_r == ST_WR ||
        st_r == ST_WB);

    // descriptor word written back
    assign wb_word = short_mode ? ((idx_r == 2'd0) ? {mra_r, sar_r[23:0]} :
        (idx_r == 2'd1) ? {mrb_r, dar_r[23:0]} : {cra_r, crb_r}) :
        (idx_r == 2'd0) ? {mra_r, mrb_r, 16'h0000} :
        (idx_r == 2'd1) ? sar_r : (idx_r == 2'd2) ? dar_r : {cra_r, crb_r};

    // access issued by each state
    always_comb begin
        acc_we = 1'b0;
        acc_size = 2'b10;
        acc_addr = 32'h0000_0000;
        acc_wdata = 32'h0000_0000;
        unique case (st_r)
            ST_VEC: acc_addr = vbr_r + {27'h000_0000, src_r, 2'b00};
            ST_DESC: acc_addr = desc_addr_r + {28'h000_0000, idx_r, 2'b00};
            ST_RD: begin
                acc_addr = sar_r;
                acc_size = sz;
            end
            ST_WR: begin
                acc_we = 1'b1;
                acc_addr = dar_r;
                acc_size = sz;
                acc_wdata = data_r;
            end
            ST_WB: begin
                acc_we = 1'b1;
                acc_addr = desc_addr_r + {28'h000_0000, idx_r, 2'b00};
                acc_wdata = wb_word;
            end
            default: acc_we = 1'b0;
        endcase
    end

    // bus request held until acknowledged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mreq_r <= '0;
        end else if (issue) begin
            mreq_r <= '{req: 1'b1, we: acc_we, size: acc_size,
                addr: acc_addr, wdata: acc_wdata};
        end else if (got) begin
            mreq_r.req <= 1'b0;
        end
    end

    assign mem_req = mreq_r;
    assign act_ack = ack_r;
    assign cpu_irq = irq_r;

    // transfer sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_IDLE;
            src_r <= 3'd0;
            last_src_r <= 3'd0;
            cache_ok_r <= 1'b0;
            desc_addr_r <= 32'h0000_0000;
            idx_r <= 2'd0;
            mra_r <= 8'h00;
            mrb_r <= 8'h00;
            sar_r <= 32'h0000_0000;
            dar_r <= 32'h0000_0000;
            cra_r <= 16'h0000;
            crb_r <= 16'h0000;
            data_r <= 32'h0000_0000;
            fin_r <= 1'b0;
            gap_r <= 1'b0;
            ack_r <= 8'h00;
            irq_r <= 8'h00;
            enclr_r <= 8'h00;
        end else begin
            ack_r <= 8'h00;
            irq_r <= 8'h00;
            enclr_r <= 8'h00;
            gap_r <= got && (brel == `BREL_ACCESS ||
                (brel == `BREL_UNIT && st_r == ST_WR));
            if (cfg_wr) begin
                cache_ok_r <= 1'b0;
            end
            unique case (st_r)
                ST_IDLE: begin
                    fin_r <= 1'b0;
                    if (!ctrl_r[`CTRL_STOP] && pend != 8'h00) begin
                        src_r <= pick;
                        idx_r <= 2'd0;
                        if (ctrl_r[`CTRL_SKIP] && cache_ok_r && !cfg_wr &&
                                pick == last_src_r) begin
                            st_r <= ST_RD;
                        end else begin
                            st_r <= ST_VEC;
                        end
                    end
                end
                ST_VEC: if (got) begin
                    desc_addr_r <= {mem_rsp.rdata[31:2], 2'b00};
                    idx_r <= 2'd0;
                    st_r <= ST_DESC;
                end
                ST_DESC: if (got) begin
                    if (idx_r == 2'd0) begin
                        mra_r <= mem_rsp.rdata[31:24];
                        if (short_mode) begin
                            sar_r <= {{8{mem_rsp.rdata[23]}},
                                mem_rsp.rdata[23:0]};
                        end else begin
                            mrb_r <= mem_rsp.rdata[23:16];
                        end
                    end else if (idx_r == 2'd1) begin
                        if (short_mode) begin
                            mrb_r <= mem_rsp.rdata[31:24];
                            dar_r <= {{8{mem_rsp.rdata[23]}},
                                mem_rsp.rdata[23:0]};
                        end else begin
                            sar_r <= mem_rsp.rdata;
                        end
                    end else if (idx_r == 2'd2 && !short_mode) begin
                        dar_r <= mem_rsp.rdata;
                    end else begin
                        cra_r <= mem_rsp.rdata[31:16];
                        crb_r <= mem_rsp.rdata[15:0];
                    end
                    if (idx_r == last_idx) begin
                        st_r <= ST_RD;
                    end else begin
                        idx_r <= idx_r + 2'd1;
                    end
                end
                ST_RD: if (got) begin
                    data_r <= mem_rsp.rdata;
                    st_r <= ST_WR;
                end
                ST_WR: if (got) begin
                    idx_r <= 2'd0;
                    st_r <= ST_WB;
                    sar_r <= sar_r + sar_step;
                    dar_r <= dar_r + dar_step;
                    if (md == `MD_REPEAT || md == `MD_BLOCK) begin
                        if (cra_r[7:0] == 8'h01) begin
                            cra_r[7:0] <= cra_r[15:8];
                            if (md == `MD_BLOCK) begin
                                crb_r <= crb_r - 16'h0001;
                                fin_r <= crb_r == 16'h0001;
                            end
                            if (mrb_r[`DTS_BIT]) begin
                                sar_r <= rewind(sar_r + sar_step,
                                    mra_r[`SM_LSB +: 2], sz, cra_r[15:8]);
                            end else begin
                                dar_r <= rewind(dar_r + dar_step,
                                    mrb_r[`DM_LSB +: 2], sz, cra_r[15:8]);
                            end
                        end else begin
                            cra_r[7:0] <= cra_r[7:0] - 8'h01;
                            if (md == `MD_BLOCK) begin
                                st_r <= ST_RD;
                            end
                        end
                    end else begin
                        cra_r <= cra_r - 16'h0001;
                        fin_r <= cra_r == 16'h0001;
                    end
                end
                ST_WB: if (got) begin
                    if (idx_r != last_idx) begin
                        idx_r <= idx_r + 2'd1;
                    end else begin
                        irq_r[src_r] <= fin_r | mrb_r[`DISEL_BIT];
                        enclr_r[src_r] <= fin_r;
                        if (mrb_r[`CHNE_BIT] &&
                                (!mrb_r[`CHNS_BIT] || fin_r)) begin
                            desc_addr_r <= desc_addr_r + (short_mode ?
                                `DESC_BYTES_SHORT : `DESC_BYTES_FULL);
                            idx_r <= 2'd0;
                            fin_r <= 1'b0;
                            cache_ok_r <= 1'b0;
                            st_r <= ST_DESC;
                        end else begin
                            ack_r[src_r] <= 1'b1;
                            last_src_r <= src_r;
                            cache_ok_r <= !cfg_wr;
                            st_r <= ST_GAP;
                        end
                    end
                end
                ST_GAP: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

endmodule : vectored_transfer_engine

`default_nettype wire

/* File: core/vte_map.svh */
`ifndef VTE_MAP_SVH
`define VTE_MAP_SVH

// apb register byte offsets
`define OFS_CTRL 8'h00
`define OFS_VBR 8'h04
`define OFS_ENABLE 8'h08
`define OFS_STATUS 8'h0C
`define OFS_DONE 8'h10

// control register bit positions
`define CTRL_STOP 0
`define CTRL_SKIP 1
`define CTRL_SHORT 2
`define CTRL_BREL 3
`define CTRL_PRIO 5

// reset values
`define CTRL_RST 32'h0000_0000
`define VBR_RST 32'h0000_0000
`define ENABLE_RST 8'h00

// first mode byte fields
`define MD_LSB 6
`define SZ_LSB 4
`define SM_LSB 2
// second mode byte fields
`define CHNE_BIT 7
`define CHNS_BIT 6
`define DISEL_BIT 5
`define DTS_BIT 4
`define DM_LSB 2

// field codes
`define MD_NORMAL 2'b00
`define MD_REPEAT 2'b01
`define MD_BLOCK 2'b10
`define SZ_BYTE 2'b00
`define AM_FIXED 2'b00
`define AM_INC 2'b10
`define AM_DEC 2'b11
`define BREL_ACCESS 2'b00
`define BREL_UNIT 2'b01

// descriptor layout
`define DESC_LAST_FULL 2'd3
`define DESC_LAST_SHORT 2'd2
`define DESC_BYTES_FULL 32'h0000_0010
`define DESC_BYTES_SHORT 32'h0000_000C

`endif

/* File: core/vte_pkg.sv */
package vte_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_VEC, ST_DESC, ST_RD, ST_WR, ST_WB, ST_GAP
    } state_type;

    typedef struct packed {
        logic req;
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } mem_rsp_type;

endpackage : vte_pkg

/* File: bench/vte_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vte_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // internal bus
    input wire vte_pkg::mem_req_type mem_req,
    output vte_pkg::mem_rsp_type mem_rsp,
    // pacing: 1 adds three wait cycles
    input wire logic slow
);
    import vte_pkg::*;
    logic [31:0] mem [logic [31:0]];
    logic [1:0] wait_r;
    logic [31:0] word;
    // one access at a time, held until ack
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_rsp <= '0;
            wait_r <= 2'h0;
        end else if (mem_req.req && !mem_rsp.ack && slow && wait_r != 2'h3) begin
            wait_r <= wait_r + 2'h1;
            mem_rsp.rdata <= ~mem_rsp.rdata;
        end else if (mem_req.req && !mem_rsp.ack) begin
            wait_r <= 2'h0;
            mem_rsp.ack <= 1'b1;
            word = mem.exists(mem_req.addr) ? mem[mem_req.addr] : 32'h0;
            if (mem_req.size == 2'b00) begin
                word = {24'h0, word[7:0]};
            end else if (mem_req.size == 2'b01) begin
                word = {16'h0, word[15:0]};
            end
            if (mem_req.we) begin
                mem[mem_req.addr] = mem_req.wdata;
            end
            mem_rsp.rdata <= word;
        end else begin
            mem_rsp.ack <= 1'b0;
            mem_rsp.rdata <= ~mem_rsp.rdata;
        end
    end
endmodule : vte_mem_model
`default_nettype wire

/* File: bench/vectored_transfer_engine_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vte_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // sources
    input wire logic [7:0] act_req,
    input wire logic [7:0] act_ack,
    input wire logic [7:0] cpu_irq,
    // internal bus
    input wire vte_pkg::mem_req_type mem_req,
    input wire vte_pkg::mem_rsp_type mem_rsp
);
    import vte_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_waiting;
        mem_req.req && !mem_rsp.ack;
    endsequence
    property p_req_hold;
        s_waiting |=> mem_req.req && $stable(mem_req);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("bus request changed before ack");
    property p_req_drop;
        mem_rsp.ack |=> !mem_req.req [*2];
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("bus request held after ack");
    property p_irq_after_wb;
        (|cpu_irq) |-> $past(mem_rsp.ack) && $past(mem_req.we);
    endproperty
    a_irq_after_wb: assert property (p_irq_after_wb)
        else $error("cpu interrupt not after writeback ack");
    property p_ack_after_wb;
        (|act_ack) |-> $past(mem_rsp.ack) && $past(mem_req.we);
    endproperty
    a_ack_after_wb: assert property (p_ack_after_wb)
        else $error("source released before writeback");
    property p_ack_onehot;
        $onehot0(act_ack);
    endproperty
    a_ack_onehot: assert property (p_ack_onehot)
        else $error("several sources acknowledged");
    property p_irq_onehot;
        $onehot0(cpu_irq);
    endproperty
    a_irq_onehot: assert property (p_irq_onehot)
        else $error("several cpu interrupts at once");
    property p_ack_pulse;
        (|act_ack) |=> act_ack == 8'h00 [*2];
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("source ack not a single pulse");
    property p_irq_source;
        (cpu_irq & ~act_req) == 8'h00;
    endproperty
    a_irq_source: assert property (p_irq_source)
        else $error("interrupt without activating request");
    property p_ack_source;
        (act_ack & ~act_req) == 8'h00;
    endproperty
    a_ack_source: assert property (p_ack_source)
        else $error("ack for a source not requesting");
    property p_unmapped;
        psel && penable && !pwrite && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
endmodule : vte_properties
`default_nettype wire
bind vectored_transfer_engine vte_properties u_props (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pslverr(pslverr),
    .act_req(act_req), .act_ack(act_ack), .cpu_irq(cpu_irq),
    .mem_req(mem_req), .mem_rsp(mem_rsp));

/* File: bench/vectored_transfer_engine_tb_top.sv */
`include "vte_map.svh"
`timescale 1ns/1ps
`default_nettype none
module vectored_transfer_engine_tb_top;
    import vte_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
    logic [7:0] paddr, act_req, act_ack, cpu_irq;
    logic [31:0] pwdata, prdata, rd;
    mem_req_type mem_req;
    mem_rsp_type mem_rsp;
    int mismatches, check_count, irqs;
    vectored_transfer_engine dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .act_req(act_req), .act_ack(act_ack),
        .cpu_irq(cpu_irq), .mem_req(mem_req), .mem_rsp(mem_rsp));
    vte_mem_model model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .slow(slow));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = {prdata[31:1], prdata[0] & !pslverr};
        if (pslverr === 1'b1) rd = 32'hffff_ffff;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic activate(input int s);
        int k;
        act_req[s] <= 1'b1;
        for (k = 0; k < 300; k++) begin
            @(posedge pclk);
            if (cpu_irq[s] === 1'b1) irqs++;
            if (act_ack[s] === 1'b1) break;
        end
        if (k == 300) mismatches++;
        act_req[s] <= 1'b0;
        @(posedge pclk);
    endtask : activate
    task automatic set_desc(input int s, input logic [15:0] md,
            input logic [31:0] source_address, destination_address, input logic [15:0] cnt);
        logic [31:0] d;
        d = 32'h0000_2000 + 32'(16 * s);
        model.mem[32'h0000_1000 + 32'(4 * s)] = d;
        model.mem[d] = {md, 16'h0000};
        model.mem[d + 32'h4] = source_address;
        model.mem[d + 32'h8] = destination_address;
        model.mem[d + 32'hc] = {cnt, 16'h0000};
    endtask : set_desc
    task automatic test_regs;
        apb(`OFS_CTRL, 1'b0, 32'h0);
        check(rd, `CTRL_RST);
        apb(`OFS_VBR, 1'b1, 32'h0000_1003);
        apb(`OFS_VBR, 1'b0, 32'h0);
        check(rd, 32'h0000_1000);
        apb(8'h20, 1'b0, 32'h0);
        check(rd, 32'hffff_ffff);
    endtask : test_regs
    // one side is always a fixed peripheral data register
    task automatic run_channel(input int s, input logic [15:0] md,
            input logic [31:0] source_address, destination_address, input int n);
        logic [31:0] d;
        logic inc_s, inc_d;
        d = 32'h0000_2000 + 32'(16 * s);
        inc_s = md[15:14] == 2'b00 && md[11:10] == `AM_INC;
        inc_d = md[3:2] == `AM_INC;
        set_desc(s, md, source_address, destination_address, 16'(n));
        apb(`OFS_ENABLE, 1'b1, 32'h1 << s);
        irqs = 0;
        for (int i = 0; i < n; i++) begin
            model.mem[source_address + (inc_s ? i : 0)] = 32'h40 + i;
            activate(s);
            check(model.mem[destination_address + (inc_d ? i : 0)], 32'h40 + i);
        end
        check(32'(irqs), 32'h1);
        check(model.mem[d + 32'h4], source_address + (inc_s ? n : 0));
        check(model.mem[d + 32'h8], destination_address + (inc_d ? n : 0));
        check({16'h0, model.mem[d + 32'hc][31:16]}, 32'h0);
        apb(`OFS_ENABLE, 1'b0, 32'h0);
        check(rd & (32'h1 << s), 32'h0);
    endtask : run_channel
    task automatic test_stop_repeat;
        int reqs;
        apb(`OFS_CTRL, 1'b1, 32'h0000_0001);
        set_desc(2, 16'h4810, 32'h0000_0300, 32'h0000_8004, 16'h0101);
        model.mem[32'h0000_0300] = 32'h5a;
        apb(`OFS_ENABLE, 1'b1, 32'h4);
        act_req[2] <= 1'b1;
        reqs = 0;
        repeat (20) begin
            @(posedge pclk);
            if (mem_req.req !== 1'b0) reqs++;
        end
        check(32'(reqs), 32'h0);
        apb(`OFS_CTRL, 1'b1, 32'h0);
        activate(2);
        check(model.mem[32'h0000_8004], 32'h5a);
        check(model.mem[32'h0000_2024], 32'h0000_0300);
        apb(`OFS_ENABLE, 1'b0, 32'h0);
        check(rd, 32'h4);
    endtask : test_stop_repeat
    // block of two longwords, chained to a one-byte normal descriptor
    task automatic test_block_chain;
        set_desc(4, 16'ha888, 32'h0000_0400, 32'h0000_0500, 16'h0202);
        model.mem[32'h0000_204c] = 32'h0202_0002;
        model.mem[32'h0000_2050] = 32'h0000_0000;
        model.mem[32'h0000_2054] = 32'h0000_0600;
        model.mem[32'h0000_2058] = 32'h0000_0700;
        model.mem[32'h0000_205c] = 32'h0001_0000;
        model.mem[32'h0000_0400] = 32'h1234_5678;
        model.mem[32'h0000_0404] = 32'h9abc_def0;
        model.mem[32'h0000_0600] = 32'h0000_00c3;
        apb(`OFS_ENABLE, 1'b1, 32'h10);
        irqs = 0;
        activate(4);
        check(model.mem[32'h0000_0500], 32'h1234_5678);
        check(model.mem[32'h0000_0504], 32'h9abc_def0);
        check(model.mem[32'h0000_0700], 32'h0000_00c3);
        check(32'(irqs), 32'h1);
        check(model.mem[32'h0000_2044], 32'h0000_0408);
        check(model.mem[32'h0000_2048], 32'h0000_0500);
        check(model.mem[32'h0000_204c], 32'h0202_0001);
        apb(`OFS_DONE, 1'b0, 32'h0);
        check(rd & 32'h10, 32'h10);
    endtask : test_block_chain
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, slow} = '0;
        {paddr, act_req, pwdata} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_regs();
        run_channel(0, 16'h0800, 32'h0000_0100, 32'h0000_8000, 32);
        slow <= 1'b1;
        run_channel(1, 16'h0008, 32'h0000_9000, 32'h0000_0200, 32);
        test_stop_repeat();
        test_block_chain();
        give_verdict();
    end
endmodule : vectored_transfer_engine_tb_top
`default_nettype wire
